// ==== pts_pkg.sv ====
// pts_pkg: shared constants, register map and carrier types for the period timer block
// assumes a 100 MHz ref_clk_i and a 32-bit Avalon-MM slave port
package pts_pkg;
  // register word offsets (byte address = offset, all multiples of four)
  localparam logic [7:0] PTS_OFS_COUNT0   = 8'h00;
  localparam logic [7:0] PTS_OFS_LIMIT0   = 8'h04;
  localparam logic [7:0] PTS_OFS_CTRL0    = 8'h08;
  localparam logic [7:0] PTS_INST_STRIDE  = 8'h10;
  localparam logic [7:0] PTS_OFS_IRQ_FLAG = 8'h30;
  localparam logic [7:0] PTS_OFS_IRQ_EN   = 8'h34;
  localparam logic [7:0] PTS_OFS_CONFIG   = 8'h38;
  // control register fields
  localparam int PTS_CTRL_PS_LSB  = 0;
  localparam int PTS_CTRL_ON_BIT  = 2;
  localparam int PTS_CTRL_POS_LSB = 3;
  localparam logic [6:0] PTS_CTRL_MASK = 7'h7F;
  // reset values
  localparam logic [7:0] PTS_COUNT_RST = 8'h00;
  localparam logic [7:0] PTS_LIMIT_RST = 8'hFF;
  localparam logic [6:0] PTS_CTRL_RST  = 7'h00;
  // prescale codes
  localparam logic [1:0] PTS_PS_DIV1  = 2'h0;
  localparam logic [1:0] PTS_PS_DIV4  = 2'h1;
  localparam logic [1:0] PTS_PS_DIV16 = 2'h2;
  localparam logic [5:0] PTS_PS_LAST4  = 6'h03;
  localparam logic [5:0] PTS_PS_LAST16 = 6'h0F;
  localparam logic [5:0] PTS_PS_LAST64 = 6'h3F;
  // instruction clock enable: ref clock divided by four
  localparam logic [1:0] PTS_ICLK_LAST = 2'h3;
  localparam logic [31:0] PTS_UNMAPPED = 32'h0000_0000;

  // software control of one timer copy
  typedef struct packed {
    logic [3:0] match_divider_select;
    logic       period_timer_on;
    logic [1:0] input_divider_select;
  } pts_ctrl_t;

  // software access strobes towards one timer copy
  typedef struct packed {
    logic       count_we;
    logic       limit_we;
    logic       ctrl_we;
    logic [7:0] wdata;
  } pts_wr_t;

  // state reported by one timer copy
  typedef struct packed {
    logic [7:0] period_count_value;
    logic [7:0] period_limit;
    logic [6:0] ctrl;
    logic       match;
    logic       flag_pulse;
  } pts_stat_t;

  // bus slave states
  typedef enum logic [1:0] {
    PTS_BUS_IDLE = 2'b00,
    PTS_BUS_ACK  = 2'b01
  } pts_bus_st_t;
endpackage

// ==== pts_scaler.sv ====
// pts_scaler: prescale divider that turns the instruction tick into counter steps
// assumes tick_i is a one-cycle pulse on ref_clk_i
`timescale 1ns/1ps
`default_nettype none
module pts_scaler (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       clr_i,
  input  wire logic       tick_i,
  input  wire logic [1:0] sel_i,
  output logic            step_o
);
  import pts_pkg::*;

  logic [5:0] cnt;
  logic [5:0] last;

  ////////////////////////////////////////////////////////////////////////
  // terminal count for each select code
  always_comb begin
    if (sel_i == PTS_PS_DIV1) begin
      last = '0;
    end else if (sel_i == PTS_PS_DIV4) begin
      last = PTS_PS_LAST4;
    end else if (sel_i == PTS_PS_DIV16) begin
      last = PTS_PS_LAST16;
    end else begin
      last = PTS_PS_LAST64;
    end
  end

  // divider counter, cleared by writes and reset
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || clr_i) begin
      cnt <= '0;
    end else if (tick_i) begin
      cnt <= (cnt >= last) ? 6'h00 : cnt + 6'h01;
    end
  end

  assign step_o = tick_i && (cnt >= last);
endmodule
`default_nettype wire

// ==== pts_timer.sv ====
// pts_timer: one copy of the 8-bit period timer with prescaler and postscaler
// assumes tick_i pulses once per instruction clock and writes come as one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
module pts_timer (
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  input  wire logic                tick_i,
  input  wire logic                sleep_i,
  input  wire pts_pkg::pts_wr_t    wr_i,
  output pts_pkg::pts_stat_t       stat_o
);
  import pts_pkg::*;

  logic [7:0] count;
  logic [7:0] limit;
  pts_ctrl_t  ctrl;
  logic [3:0] post_cnt;
  logic       restart;
  logic       step;
  logic       match;
  logic       flag_pulse;
  logic       scaler_clr;

  assign scaler_clr = wr_i.count_we || wr_i.ctrl_we;

  ////////////////////////////////////////////////////////////////////////
  // prescaler; stopped while off or asleep
  pts_scaler u_pre (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .clr_i     (scaler_clr),
    .tick_i    (tick_i && ctrl.period_timer_on && !sleep_i),
    .sel_i     (ctrl.input_divider_select),
    .step_o    (step)
  );

  // comparator: match while counter equals the limit on a counting step
  assign match = step && (count == limit);

  // control register; writing it leaves the counter alone
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl <= PTS_CTRL_RST;
    end else if (wr_i.ctrl_we) begin
      ctrl <= wr_i.wdata[6:0];
    end
  end

  // period register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      limit <= PTS_LIMIT_RST;
    end else if (wr_i.limit_we) begin
      limit <= wr_i.wdata;
    end
  end

  // counter: up from zero, back to zero on the same step that gives a match
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      count   <= PTS_COUNT_RST;
      restart <= 1'b0;
    end else if (wr_i.count_we) begin
      count   <= wr_i.wdata;
      restart <= 1'b0;
    end else if (step) begin
      count   <= match ? PTS_COUNT_RST : count + 8'h01;
      restart <= match;
    end
  end

  // postscaler counting matches
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || scaler_clr) begin
      post_cnt <= '0;
    end else if (match) begin
      post_cnt <= (post_cnt == ctrl.match_divider_select) ? 4'h0 : post_cnt + 4'h1;
    end
  end

  assign flag_pulse = match && (post_cnt == ctrl.match_divider_select);

  assign stat_o.period_count_value = count;
  assign stat_o.period_limit       = limit;
  assign stat_o.ctrl               = ctrl;
  assign stat_o.match              = match;
  assign stat_o.flag_pulse         = flag_pulse;

  ////////////////////////////////////////////////////////////////////////
  // checks
  limit_reset_a: assert property (@(posedge ref_clk_i) rst_i |=> limit == PTS_LIMIT_RST)
    else $error("limit not all ones after reset");
  match_wrap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    match && !wr_i.count_we |=> count == PTS_COUNT_RST)
    else $error("counter did not restart after match");
  ctrl_keep_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wr_i.ctrl_we && !wr_i.count_we && !step |=> $stable(count))
    else $error("control write disturbed counter");
  sleep_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    sleep_i && !wr_i.count_we |=> $stable(count))
    else $error("counter moved during sleep");
  off_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !ctrl.period_timer_on && !wr_i.count_we |=> $stable(count))
    else $error("counter moved while off");
  post_one_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    match && ctrl.match_divider_select == 4'h0 |-> flag_pulse)
    else $error("1:1 postscale missed a flag");
  post_clr_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    scaler_clr |=> post_cnt == 4'h0)
    else $error("postscaler not cleared by write");
  div1_step_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    tick_i && ctrl.period_timer_on && !sleep_i && ctrl.input_divider_select == PTS_PS_DIV1 |-> step)
    else $error("1:1 prescale missed a step");
  match_cov_c: cover property (@(posedge ref_clk_i) disable iff (rst_i) match);
  flag_cov_c: cover property (@(posedge ref_clk_i) disable iff (rst_i) flag_pulse && ctrl.match_divider_select != 4'h0);
  restart_cov_c: cover property (@(posedge ref_clk_i) disable iff (rst_i) restart ##1 step);
endmodule
`default_nettype wire

// ==== pts_top.sv ====
// pts_top: three 8-bit period timers behind an Avalon-MM slave with interrupt logic
// assumes a synchronous active-high reset and inputs synchronous to ref_clk_i
// What this block does
// - three identical period timers, each with its own counter, limit, control, flag and enable.
// - each timer runs only from the instruction clock, the reference clock divided by four.
// - the counter counts up from zero by one per prescaled step while the timer is on.
// - prescale select 00 divides by 1, 01 by 4 and 10 by 16.
// - counter equal to limit gives a match pulse and the counter goes back to zero on that same step.
// - counter and limit are readable and writable by software at any time.
// - reset clears the counter and loads the limit with all ones.
// - prescaler and postscaler clear on a counter write, a control write and any reset.
// - writing the control register leaves the counter value alone.
// - a 4-bit postscaler counts matches and sets the sticky flag; interrupt only when enabled.
// - the postscale field gives a ratio of its value plus one, 1:1 up to 1:16.
// - control holds a zero top bit, postscale in 6..3, on bit 2, prescale in 1..0, reset zero.
// - the unscaled match pulse is offered to the PWM units as a time base.
// - the first timer can supply the shift clock for the serial port in SPI mode.
// - in sleep the timers stop and keep their counter and limit values.
`timescale 1ns/1ps
`default_nettype none
module pts_top #(
  parameter int N_TIMERS = 3
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   sleep_i,
  input  wire logic [7:0]             avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output logic [31:0]                 avs_readdata_o,
  output logic                        avs_waitrequest_o,
  output logic                        irq_o,
  output logic [N_TIMERS-1:0]         pwm_time_base_o,
  output logic                        spi_shift_clk_o
);
  import pts_pkg::*;

  pts_bus_st_t              bus_st;
  logic [1:0]               iclk_cnt;
  logic                     tick;
  pts_wr_t   [N_TIMERS-1:0] wr;
  pts_stat_t [N_TIMERS-1:0] stat;
  logic [N_TIMERS-1:0]      period_match_flag;
  logic [N_TIMERS-1:0]      period_match_enable;
  logic                     spi_clk_en;
  logic                     spi_toggle;
  logic                     bus_req;
  logic                     accept;
  logic                     flag_rd;
  logic [31:0]              next_rdata;
  logic [31:0]              rdata;

  // word index match for a per-timer register
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] base, input int idx);
    logic [7:0] off;
    off = base + 8'(idx) * PTS_INST_STRIDE;
    return addr == off;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // instruction clock tick: one pulse every fourth reference cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      iclk_cnt <= '0;
    end else begin
      iclk_cnt <= iclk_cnt + 2'h1;
    end
  end
  assign tick = (iclk_cnt == PTS_ICLK_LAST);

  ////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, answer on the second edge
  assign bus_req = avs_read_i || avs_write_i;
  assign accept  = bus_req && (bus_st == PTS_BUS_ACK);
  assign avs_waitrequest_o = bus_req && (bus_st != PTS_BUS_ACK);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bus_st <= PTS_BUS_IDLE;
    end else begin
      case (bus_st)
        PTS_BUS_IDLE: begin
          if (bus_req) begin
            bus_st <= PTS_BUS_ACK;
          end
        end
        default: begin
          bus_st <= PTS_BUS_IDLE;
        end
      endcase
    end
  end

  // write strobes per timer, only on the accepting edge and low byte lane
  always_comb begin
    for (int i = 0; i < N_TIMERS; i++) begin
      wr[i].wdata    = avs_writedata_i[7:0];
      wr[i].count_we = accept && avs_write_i && avs_byteenable_i[0] && hit(avs_address_i, PTS_OFS_COUNT0, i);
      wr[i].limit_we = accept && avs_write_i && avs_byteenable_i[0] && hit(avs_address_i, PTS_OFS_LIMIT0, i);
      wr[i].ctrl_we  = accept && avs_write_i && avs_byteenable_i[0] && hit(avs_address_i, PTS_OFS_CTRL0, i);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timer copies
  genvar g;
  generate
    for (g = 0; g < N_TIMERS; g++) begin : g_tmr
      pts_timer u_tmr (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .tick_i    (tick),
        .sleep_i   (sleep_i),
        .wr_i      (wr[g]),
        .stat_o    (stat[g])
      );
      assign pwm_time_base_o[g] = stat[g].match;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    next_rdata = PTS_UNMAPPED;
    if (avs_address_i == PTS_OFS_IRQ_FLAG) begin
      next_rdata = 32'(period_match_flag);
    end else if (avs_address_i == PTS_OFS_IRQ_EN) begin
      next_rdata = 32'(period_match_enable);
    end else if (avs_address_i == PTS_OFS_CONFIG) begin
      next_rdata = 32'(spi_clk_en);
    end else begin
      for (int i = 0; i < N_TIMERS; i++) begin
        if (hit(avs_address_i, PTS_OFS_COUNT0, i)) begin
          next_rdata = 32'(stat[i].period_count_value);
        end else if (hit(avs_address_i, PTS_OFS_LIMIT0, i)) begin
          next_rdata = 32'(stat[i].period_limit);
        end else if (hit(avs_address_i, PTS_OFS_CTRL0, i)) begin
          next_rdata = 32'(stat[i].ctrl);
        end
      end
    end
  end

  // read data captured in the wait cycle, stands at the accepting edge
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata <= '0;
    end else if (bus_req && bus_st == PTS_BUS_IDLE) begin
      rdata <= next_rdata;
    end
  end
  assign avs_readdata_o = rdata;

  ////////////////////////////////////////////////////////////////////////
  // sticky flags: set by postscaler, set wins; a read clears only the bits it returned,
  // so an event landing in the wait cycle after the snapshot is not lost
  assign flag_rd = accept && avs_read_i && (avs_address_i == PTS_OFS_IRQ_FLAG);
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      period_match_flag <= '0;
    end else begin
      for (int i = 0; i < N_TIMERS; i++) begin
        if (stat[i].flag_pulse) begin
          period_match_flag[i] <= 1'b1;
        end else if (flag_rd && rdata[i]) begin
          period_match_flag[i] <= 1'b0;
        end
      end
    end
  end

  // enable mask and serial clock option
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      period_match_enable <= '0;
      spi_clk_en          <= 1'b0;
    end else if (accept && avs_write_i && avs_byteenable_i[0]) begin
      if (avs_address_i == PTS_OFS_IRQ_EN) begin
        period_match_enable <= avs_writedata_i[N_TIMERS-1:0];
      end else if (avs_address_i == PTS_OFS_CONFIG) begin
        spi_clk_en <= avs_writedata_i[0];
      end
    end
  end

  assign irq_o = |(period_match_flag & period_match_enable);

  // shift clock from the first timer: toggles on each match
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !spi_clk_en) begin
      spi_toggle <= 1'b0;
    end else if (stat[0].match) begin
      spi_toggle <= ~spi_toggle;
    end
  end
  assign spi_shift_clk_o = spi_toggle;

  ////////////////////////////////////////////////////////////////////////
  // checks
  wait_one_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    bus_req && bus_st == PTS_BUS_IDLE |=> !avs_waitrequest_o || !bus_req)
    else $error("waitrequest held longer than one cycle");
  irq_mask_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (period_match_enable == '0) |-> !irq_o)
    else $error("interrupt raised while all masked");
  flag_set_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    stat[0].flag_pulse |=> period_match_flag[0])
    else $error("flag not set by postscaler");
  spi_tog_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    spi_clk_en && stat[0].match |=> spi_shift_clk_o != $past(spi_shift_clk_o))
    else $error("shift clock did not toggle");
  tick_rate_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    tick |=> !tick ##1 !tick ##1 !tick ##1 tick)
    else $error("instruction tick not every fourth cycle");
  irq_cov_c: cover property (@(posedge ref_clk_i) disable iff (rst_i) $rose(irq_o));
  rd_clr_cov_c: cover property (@(posedge ref_clk_i) disable iff (rst_i) flag_rd && period_match_flag != '0);
endmodule
`default_nettype wire

// ==== pts_far_model.sv ====
// pts_far_model: behavioural stand-in for the PWM units and the serial port fed by the timers
// assumes time-base pulses and the shift clock are synchronous to ref_clk_i
`timescale 1ns/1ps
`default_nettype none
module pts_far_model #(
  parameter int N = 3
) (
  input  wire logic          ref_clk_i,
  input  wire logic          rst_i,
  input  wire logic [N-1:0]  time_base_i,
  input  wire logic          shift_clk_i,
  output logic [N-1:0][31:0] pulse_cnt_o,
  output logic [N-1:0][31:0] gap_o,
  output logic [31:0]        shift_edges_o
);
  logic [N-1:0][31:0] since;
  logic               shift_q;

  ////////////////////////////////////////////////////////////////////////////////
  // each PWM unit counts its time-base pulses and the cycles between the last two
  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < N; i++) begin
      if (rst_i) begin
        pulse_cnt_o[i] <= 32'h0;
        gap_o[i] <= 32'h0;
        since[i] <= 32'h0;
      end else if (time_base_i[i]) begin
        pulse_cnt_o[i] <= pulse_cnt_o[i] + 32'h1;
        gap_o[i] <= since[i] + 32'h1;
        since[i] <= 32'h0;
      end else begin
        since[i] <= since[i] + 32'h1;
      end
    end
  end

  // serial port: every change of the shift clock is one shift edge
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      shift_q <= 1'b0;
      shift_edges_o <= 32'h0;
    end else begin
      shift_q <= shift_clk_i;
      if (shift_clk_i != shift_q) begin
        shift_edges_o <= shift_edges_o + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== pts_top_test.sv ====
// pts_top_test: self-checking bench for the three period timers behind the Avalon-MM port
// assumes pts_top and pts_far_model; 100 MHz clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module pts_top_test;
  import pts_pkg::*;
  logic              ref_clk, rst, sleep, avs_read, avs_write, avs_wait, irq, spi;
  logic [7:0]        avs_address;
  logic [31:0]       avs_writedata, avs_readdata, rd, snap, snap2;
  logic [3:0]        avs_be;
  logic [2:0]        pwm;
  logic [2:0][31:0]  pcnt, gap;
  logic [31:0]       edges;
  logic [7:0]        v, c, lim, b;
  logic [3:0]        p;
  int                fails, check_count, seed, cycles, n;

  pts_top i_dut (.ref_clk_i(ref_clk), .rst_i(rst), .sleep_i(sleep), .avs_address_i(avs_address),
    .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_byteenable_i(avs_be), .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_wait),
    .irq_o(irq), .pwm_time_base_o(pwm), .spi_shift_clk_o(spi));
  pts_far_model i_far (.ref_clk_i(ref_clk), .rst_i(rst), .time_base_i(pwm), .shift_clk_i(spi),
    .pulse_cnt_o(pcnt), .gap_o(gap), .shift_edges_o(edges));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fails++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus cycles: request held until waitrequest is seen low at an edge
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= d;
    avs_be <= be;
    avs_write <= 1'b1;
    @(posedge ref_clk);
    while (avs_wait !== 1'b0) @(posedge ref_clk);
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge ref_clk);
    while (avs_wait !== 1'b0) @(posedge ref_clk);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wait_clk(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  // comparisons of register values and of event counts
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD register t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD count t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // expected figures
  function automatic logic [7:0] base(input int i);
    return 8'(i) * PTS_INST_STRIDE;
  endfunction
  function automatic logic [31:0] exp_period(input logic [7:0] l, input logic [1:0] ps);
    return ({24'h0, l} + 32'h1) * 32'h4 << (2 * ps);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    ref_clk = 1'b0; rst = 1'b1; sleep = 1'b0; avs_read = 1'b0; avs_write = 1'b0;
    avs_address = 8'h00; avs_writedata = 32'h0; avs_be = 4'hF;
    fails = 0; check_count = 0; cycles = 0; seed = 94806;
    wait_clk(16);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 3; i++) begin
      bus_rd(base(i) + PTS_OFS_COUNT0, rd); chk_reg(rd, 32'h00);
      bus_rd(base(i) + PTS_OFS_LIMIT0, rd); chk_reg(rd, 32'hFF);
      bus_rd(base(i) + PTS_OFS_CTRL0, rd); chk_reg(rd, 32'h00);
    end
    bus_rd(PTS_OFS_IRQ_FLAG, rd); chk_reg(rd, 32'h0);
    bus_rd(PTS_OFS_IRQ_EN, rd); chk_reg(rd, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 3; i++) begin
      v = 8'($random(seed));
      b = 8'($random(seed));
      c = 8'($random(seed)) & 8'hFB;
      bus_wr(base(i) + PTS_OFS_COUNT0, {24'h0, v}, 4'hF);
      bus_rd(base(i) + PTS_OFS_COUNT0, rd); chk_reg(rd, {24'h0, v});
      bus_wr(base(i) + PTS_OFS_LIMIT0, {24'h0, b}, 4'hF);
      bus_rd(base(i) + PTS_OFS_LIMIT0, rd); chk_reg(rd, {24'h0, b});
      bus_wr(base(i) + PTS_OFS_CTRL0, {24'h0, c | 8'h80}, 4'hF);
      bus_rd(base(i) + PTS_OFS_CTRL0, rd); chk_reg(rd, {25'h0, c[6:0]});
      bus_rd(base(i) + PTS_OFS_COUNT0, rd); chk_reg(rd, {24'h0, v});
      bus_wr(base(i) + PTS_OFS_COUNT0, {24'h0, ~v}, 4'hE);
      bus_rd(base(i) + PTS_OFS_COUNT0, rd); chk_reg(rd, {24'h0, v});
    end
    bus_wr(8'hFC, 32'hFFFF_FFFF, 4'hF);
    bus_rd(8'hFC, rd); chk_reg(rd, 32'h0);
    $display("test register access done");
    // every prescale code on every copy: period between match pulses
    for (int i = 0; i < 3; i++) begin
      for (int ps = 0; ps < 4; ps++) begin
        lim = 8'($random(seed)) & 8'h07;
        bus_wr(base(i) + PTS_OFS_LIMIT0, {24'h0, lim}, 4'hF);
        bus_wr(base(i) + PTS_OFS_COUNT0, 32'h0, 4'hF);
        bus_wr(base(i) + PTS_OFS_CTRL0, 32'(4 + ps), 4'hF);
        snap = pcnt[i];
        n = 0;
        while (pcnt[i] - snap < 32'd2 && n < 7000) begin
          @(posedge ref_clk);
          n++;
        end
        chk_cnt(gap[i], exp_period(lim, 2'(ps)));
        bus_wr(base(i) + PTS_OFS_CTRL0, 32'h0, 4'hF);
      end
    end
    $display("test prescale periods done");
    // postscaler, sticky flag, mask and clear on read
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($random(seed));
      bus_wr(base(i) + PTS_OFS_LIMIT0, 32'h1, 4'hF);
      bus_wr(base(i) + PTS_OFS_COUNT0, 32'h0, 4'hF);
      bus_wr(PTS_OFS_IRQ_EN, 32'h1 << i, 4'hF);
      bus_rd(PTS_OFS_IRQ_FLAG, rd);
      snap = pcnt[i];
      bus_wr(base(i) + PTS_OFS_CTRL0, {25'h0, p, 1'b1, 2'b00}, 4'hF);
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
        @(posedge ref_clk);
        n++;
      end
      chk_cnt(pcnt[i] - snap, {28'h0, p} + 32'h1);
      bus_wr(base(i) + PTS_OFS_CTRL0, 32'h0, 4'hF);
      bus_wr(PTS_OFS_IRQ_EN, 32'h0, 4'hF);
      chk_reg({31'h0, irq}, 32'h0);
      bus_rd(PTS_OFS_IRQ_FLAG, rd); chk_reg(rd, 32'h1 << i);
      bus_rd(PTS_OFS_IRQ_FLAG, rd); chk_reg(rd, 32'h0);
    end
    $display("test postscaler and interrupt done");
    // sleep freezes the counter
    bus_wr(base(2) + PTS_OFS_LIMIT0, 32'hFF, 4'hF);
    bus_wr(base(2) + PTS_OFS_COUNT0, 32'h0, 4'hF);
    bus_wr(base(2) + PTS_OFS_CTRL0, 32'h4, 4'hF);
    wait_clk(40);
    sleep <= 1'b1;
    wait_clk(2);
    bus_rd(base(2) + PTS_OFS_COUNT0, snap);
    wait_clk(60);
    bus_rd(base(2) + PTS_OFS_COUNT0, rd); chk_reg(rd, snap);
    bus_rd(base(2) + PTS_OFS_LIMIT0, rd); chk_reg(rd, 32'hFF);
    sleep <= 1'b0;
    bus_wr(base(2) + PTS_OFS_CTRL0, 32'h0, 4'hF);
    $display("test sleep done");
    // first copy drives the serial shift clock once enabled
    bus_wr(PTS_OFS_CONFIG, 32'h1, 4'hF);
    bus_wr(PTS_OFS_LIMIT0, 32'h1, 4'hF);
    bus_wr(PTS_OFS_COUNT0, 32'h0, 4'hF);
    wait_clk(4);
    snap = edges;
    snap2 = pcnt[0];
    bus_wr(PTS_OFS_CTRL0, 32'h4, 4'hF);
    wait_clk(100);
    bus_wr(PTS_OFS_CTRL0, 32'h0, 4'hF);
    wait_clk(4);
    chk_cnt(edges - snap, pcnt[0] - snap2);
    chk_cnt(32'(pcnt[0] - snap2 > 32'd10), 32'h1);
    bus_wr(PTS_OFS_CONFIG, 32'h0, 4'hF);
    wait_clk(2);
    chk_reg({31'h0, spi}, 32'h0);
    $display("test shift clock done");
    summarize();
  end
endmodule
`default_nettype wire
